// ### sfl_regs.svh
// Constants for the flash lock and soft-reset command block
`ifndef SFL_REGS_SVH
`define SFL_REGS_SVH
`define SFL_OP_LOCK_ONE 8'h36
`define SFL_OP_UNLOCK_ONE 8'h39
`define SFL_OP_READ_LOCK 8'h3D
`define SFL_OP_LOCK_ALL 8'h7E
`define SFL_OP_UNLOCK_ALL 8'h98
`define SFL_OP_RST_ARM 8'h66
`define SFL_OP_RST_GO 8'h99
`define SFL_LOCK_RESET 1'b1
`define SFL_CLK_MHZ 100
`define SFL_TRST_US 30
`define SFL_TRST_CYC (`SFL_TRST_US * `SFL_CLK_MHZ)
`define SFL_UNIT_SHIFT 16
`endif

// ### sfl_pkg.sv
// Types for the flash lock and soft-reset command block
package sfl_pkg;
  typedef enum logic [4:0] {
    SFL_IDLE = 5'h01,
    SFL_OPC = 5'h02,
    SFL_ADDR = 5'h04,
    SFL_READ = 5'h08,
    SFL_DONE = 5'h10
  } sfl_state_t;
endpackage

// ### sfl_lock_if.sv
// Interface between command logic and lock-bit store
`timescale 1ns/10ps
interface sfl_lock_if #(parameter int UNITS = 512);
  logic wr_one;
  logic wr_all;
  logic wr_val;
  logic [$clog2(UNITS)-1:0] idx;
  logic rd_bit;
  modport ctl (output wr_one, output wr_all, output wr_val, output idx, input rd_bit);
  modport mem (input wr_one, input wr_all, input wr_val, input idx, output rd_bit);
endinterface

// ### sfl_lock_mem.sv
// Volatile lock-bit store, one bit per block or sector
`timescale 1ns/10ps
module sfl_lock_mem #(
  parameter int UNITS = 512
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  sfl_lock_if.mem lk
);
  `include "sfl_regs.svh"
  logic [UNITS-1:0] bits_q;
  logic rd_q;

  // All units lock at reset [RULE_02]
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      bits_q <= {UNITS{`SFL_LOCK_RESET}};
    end else if (clk_en) begin
      if (lk.wr_all) begin
        bits_q <= {UNITS{lk.wr_val}}; // [RULE_07] [RULE_08]
      end else if (lk.wr_one) begin
        bits_q[lk.idx] <= lk.wr_val; // [RULE_03] [RULE_13]
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      rd_q <= `SFL_LOCK_RESET;
    end else if (clk_en) begin
      rd_q <= bits_q[lk.idx];
    end
  end

  assign lk.rd_bit = rd_q;
endmodule

// ### sfl_cmd.sv
// Lock-bit and software-reset command interpreter of a serial flash
`timescale 1ns/10ps
`include "sfl_regs.svh"
// Notes on behaviour
// RULE_01: Lock bits protect only while the scheme-select bit is 1, else level bits rule.
// RULE_02: Lock bits are volatile and all set to 1 after power-up or reset.
// RULE_03: Command 39h with an address clears the addressed unit's lock bit.
// RULE_04: Opcode and address bits are sampled on rising serial-clock edges.
// RULE_05: Command 3Dh with an address shifts the lock byte out MSB first on falling edges.
// RULE_06: The readback byte's LSB is 1 for locked, 0 for unlocked.
// RULE_07: Command 7Eh alone sets every lock bit.
// RULE_08: Command 98h alone clears every lock bit.
// RULE_09: Reset runs only when 66h is directly followed by 99h; anything else disarms.
// RULE_10: An accepted reset returns all volatile state to power-on values.
// RULE_11: After a reset all commands are ignored for about 30 us.
// RULE_12: The host should check busy and suspend clear before the reset pair.
// RULE_13: Command 36h with an address sets the addressed unit's lock bit.
// RULE_14: Each address maps to the lock bit of the unit containing it.
module sfl_cmd
  import sfl_pkg::*;
#(
  parameter int UNITS = 512,
  parameter int TRST_CYC = `SFL_TRST_CYC
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic cs_b,
  input wire logic sclk,
  input wire logic serial_in,
  input wire logic addr4_mode,
  input wire logic protect_scheme_select,
  input wire logic protect_complement,
  input wire logic top_bottom_select,
  input wire logic [3:0] block_protect_level,
  input wire logic write_enable_latch_set,
  input wire logic suspend_set,
  input wire logic busy,
  input wire logic [7:0] read_param_in,
  input wire logic read_param_load,
  input wire logic [7:0] cont_read_in,
  input wire logic cont_read_load,
  input wire logic [31:0] query_addr,
  output logic serial_out,
  output logic serial_out_en_b,
  output logic query_locked,
  output logic lock_scheme_active,
  output logic abort_op,
  output logic reset_busy,
  output logic write_enable_latch,
  output logic suspend_flag,
  output logic [7:0] read_param_bits,
  output logic [7:0] continuous_read_bits
);
  localparam int IW = $clog2(UNITS);
  localparam int CW = $clog2(TRST_CYC + 1);

  // Unit index is a plain slice, so the unit count must be a power of two
  if (UNITS < 2 || UNITS > 65536 || (UNITS & (UNITS - 1)) != 0
      || TRST_CYC < 1) begin : g_bad_param
    $error("sfl_cmd: bad parameters");
  end

  sfl_lock_if #(.UNITS(UNITS)) lk ();
  sfl_lock_mem #(.UNITS(UNITS)) u_mem (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .lk(lk)
  );

  // ****************************************
  // Serial pin sampling and edge detection
  // ****************************************
  sfl_state_t state_q;
  logic sclk_q, cs_q;
  logic [7:0] sh_q;
  logic [5:0] cnt_q;
  logic [7:0] op_q;
  logic [31:0] addr_q;
  logic armed_q;
  logic [CW-1:0] rec_q;
  logic [7:0] out_q;
  logic soft_rst;
  logic rise, fall, cs_rise;
  logic [5:0] addr_bits;
  logic known_addr_op;
  logic addr_done_q;

  assign rise = sclk & ~sclk_q & ~cs_b; // [RULE_04]
  assign fall = ~sclk & sclk_q & ~cs_b;
  assign cs_rise = cs_b & ~cs_q;
  assign addr_bits = addr4_mode ? 6'd32 : 6'd24;
  assign known_addr_op = (op_q == `SFL_OP_LOCK_ONE) || (op_q == `SFL_OP_UNLOCK_ONE)
    || (op_q == `SFL_OP_READ_LOCK);

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      sclk_q <= 1'b0;
      cs_q <= 1'b1;
    end else if (clk_en) begin
      sclk_q <= sclk;
      cs_q <= cs_b;
    end
  end

  // ****************************************
  // Command framing state machine
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (!rst_b || soft_rst) begin
      state_q <= SFL_IDLE;
      cnt_q <= 6'd0;
      sh_q <= 8'h00;
      op_q <= 8'h00;
      addr_q <= 32'h0000_0000;
    end else if (clk_en) begin
      if (cs_b) begin
        state_q <= SFL_IDLE;
        cnt_q <= 6'd0;
      end else begin
        case (state_q)
          SFL_IDLE: begin
            // Ignore frames during reset recovery [RULE_11]
            state_q <= (rec_q != '0) ? SFL_DONE : SFL_OPC;
            cnt_q <= 6'd0;
          end
          SFL_OPC: begin
            if (rise) begin
              sh_q <= {sh_q[6:0], serial_in}; // [RULE_04]
              cnt_q <= cnt_q + 6'd1;
              if (cnt_q == 6'd7) begin
                op_q <= {sh_q[6:0], serial_in};
                cnt_q <= 6'd0;
                state_q <= SFL_ADDR;
              end
            end
          end
          SFL_ADDR: begin
            if (rise && known_addr_op) begin
              addr_q <= {addr_q[30:0], serial_in}; // [RULE_04]
              cnt_q <= cnt_q + 6'd1;
              if (cnt_q == addr_bits - 6'd1) begin
                cnt_q <= 6'd0;
                state_q <= (op_q == `SFL_OP_READ_LOCK) ? SFL_READ : SFL_DONE;
              end
            end else if (rise) begin
              state_q <= SFL_DONE; // Extra clocks spoil a one-byte command
            end
          end
          SFL_READ: begin
            if (fall) begin
              cnt_q <= cnt_q + 6'd1;
            end
          end
          SFL_DONE: state_q <= SFL_DONE;
          default: state_q <= SFL_IDLE;
        endcase
      end
    end
  end

  // Only the top address bits pick the unit; uniform granularity [RULE_14]
  logic [31:0] eff_addr;
  logic [31:0] unit_full;
  assign eff_addr = addr4_mode ? addr_q : {8'h00, addr_q[23:0]};
  assign unit_full = eff_addr >> `SFL_UNIT_SHIFT;

  // ****************************************
  // Command execution at select release
  // ****************************************
  logic exec;
  logic lock_cmd_ok;
  assign exec = cs_rise && (state_q == SFL_ADDR) && (rec_q == '0);
  assign lock_cmd_ok = exec && (cnt_q == 6'd0);

  always_comb begin
    lk.wr_one = 1'b0;
    lk.wr_all = 1'b0;
    lk.wr_val = 1'b0;
    // Frame address owns the port until the frame has closed
    lk.idx = (state_q != SFL_IDLE) ? unit_full[IW-1:0]
      : query_addr[`SFL_UNIT_SHIFT +: IW];
    if (lock_cmd_ok) begin
      case (op_q)
        `SFL_OP_LOCK_ALL: begin
          lk.wr_all = 1'b1; // [RULE_07]
          lk.wr_val = 1'b1;
        end
        `SFL_OP_UNLOCK_ALL: lk.wr_all = 1'b1; // [RULE_08]
        default: lk.wr_all = 1'b0;
      endcase
    end
    // Address commands commit once full address is in
    if (cs_rise && state_q == SFL_DONE && rec_q == '0 && cnt_q == 6'd0) begin
      if (op_q == `SFL_OP_LOCK_ONE && addr_done_q) begin
        lk.wr_one = 1'b1; // [RULE_13]
        lk.wr_val = 1'b1;
      end else if (op_q == `SFL_OP_UNLOCK_ONE && addr_done_q) begin
        lk.wr_one = 1'b1; // [RULE_03]
        lk.wr_val = 1'b0;
      end
    end
    // Soft reset relocks the whole array [RULE_02] [RULE_10]
    if (soft_rst) begin
      lk.wr_all = 1'b1;
      lk.wr_val = `SFL_LOCK_RESET;
    end
  end

  // Marks a complete address with no trailing clocks
  always_ff @(posedge ref_clk) begin
    if (!rst_b || soft_rst) begin
      addr_done_q <= 1'b0;
    end else if (clk_en) begin
      if (cs_b) begin
        addr_done_q <= 1'b0;
      end else if (state_q == SFL_ADDR && rise && known_addr_op
          && cnt_q == addr_bits - 6'd1) begin
        addr_done_q <= 1'b1;
      end else if (state_q == SFL_DONE && rise) begin
        addr_done_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // Lock readback shifter
  // ****************************************
  // Read data lags one ref_clk; sclk must be well below ref_clk
  always_ff @(posedge ref_clk) begin
    if (!rst_b || soft_rst) begin
      out_q <= 8'h00;
      serial_out <= 1'b0;
      serial_out_en_b <= 1'b1;
    end else if (clk_en) begin
      if (state_q != SFL_READ || cs_b) begin
        serial_out_en_b <= 1'b1;
        out_q <= {7'h00, lk.rd_bit}; // [RULE_06]
        serial_out <= 1'b0;
      end else if (fall) begin
        serial_out_en_b <= 1'b0;
        serial_out <= out_q[7]; // [RULE_05]
        out_q <= (cnt_q[2:0] == 3'd7) ? {7'h00, lk.rd_bit} : {out_q[6:0], 1'b0};
      end else if (cnt_q == 6'd0) begin
        // Reload until the new address has reached the store
        out_q <= {7'h00, lk.rd_bit}; // [RULE_06]
      end
    end
  end

  // ****************************************
  // Software reset pair and recovery
  // ****************************************
  logic op_end;
  assign op_end = cs_rise && (state_q != SFL_IDLE) && (rec_q == '0) && (cnt_q == 6'd0)
    && (state_q == SFL_ADDR);
  assign soft_rst = clk_en && op_end && armed_q && (op_q == `SFL_OP_RST_GO); // [RULE_09]

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      armed_q <= 1'b0;
    end else if (clk_en) begin
      if (soft_rst) begin
        armed_q <= 1'b0;
      end else if (cs_rise && state_q != SFL_IDLE && rec_q == '0) begin
        armed_q <= op_end && (op_q == `SFL_OP_RST_ARM); // [RULE_09]
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      rec_q <= '0;
      reset_busy <= 1'b0;
      abort_op <= 1'b0;
    end else if (clk_en) begin
      abort_op <= soft_rst; // [RULE_10]
      if (soft_rst) begin
        rec_q <= CW'(TRST_CYC); // [RULE_11]
        reset_busy <= 1'b1;
      end else if (rec_q != '0) begin
        rec_q <= rec_q - CW'(1);
        reset_busy <= (rec_q != CW'(1));
      end
    end
  end

  // ****************************************
  // Volatile settings lost on reset
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (!rst_b || soft_rst) begin
      write_enable_latch <= 1'b0; // [RULE_10]
      suspend_flag <= 1'b0;
      read_param_bits <= 8'h00;
      continuous_read_bits <= 8'h00;
    end else if (clk_en) begin
      if (write_enable_latch_set) write_enable_latch <= 1'b1;
      if (suspend_set && !busy) suspend_flag <= 1'b1;
      if (read_param_load) read_param_bits <= read_param_in;
      if (cont_read_load) continuous_read_bits <= cont_read_in;
    end
  end

  // ****************************************
  // Protection scheme selection
  // ****************************************
  // Level-based scheme lives elsewhere; here lock bits gate only under select
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      query_locked <= 1'b0;
      lock_scheme_active <= 1'b0;
    end else if (clk_en) begin
      lock_scheme_active <= protect_scheme_select; // [RULE_01]
      query_locked <= protect_scheme_select & lk.rd_bit; // [RULE_01]
    end
  end

endmodule

// ### sfl_cmd_asserts.sv
// Port-level assertions for the lock and soft-reset command block
`timescale 1ns/10ps
module sfl_cmd_asserts #(
  parameter int TRST_CYC = 3000
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic cs_b,
  input wire logic protect_scheme_select,
  input wire logic serial_out_en_b,
  input wire logic query_locked,
  input wire logic lock_scheme_active,
  input wire logic abort_op,
  input wire logic reset_busy,
  input wire logic write_enable_latch,
  input wire logic suspend_flag,
  input wire logic [7:0] read_param_bits,
  input wire logic [7:0] continuous_read_bits
);
  logic [31:0] busy_cnt_q;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // Length of the current recovery stretch
  always_ff @(posedge ref_clk) begin
    if (!rst_b || !reset_busy) begin
      busy_cnt_q <= 32'h0;
    end else begin
      busy_cnt_q <= busy_cnt_q + 32'h1;
    end
  end
  AST_SCHEME_FOLLOW: assert property (clk_en
      |=> lock_scheme_active == $past(protect_scheme_select))
    else $error("scheme flag does not follow select");
  AST_SCHEME_OFF: assert property ((clk_en && !protect_scheme_select) [*2]
      |=> !query_locked)
    else $error("lock reported while scheme is off");
  AST_ABORT_PULSE: assert property (abort_op |=> !abort_op)
    else $error("abort longer than one cycle");
  AST_ABORT_BUSY: assert property (abort_op |-> ##[0:2] reset_busy)
    else $error("no recovery after reset");
  AST_BUSY_LEN: assert property ($fell(reset_busy)
      |-> busy_cnt_q >= TRST_CYC - 1 && busy_cnt_q <= TRST_CYC + 1)
    else $error("recovery length wrong");
  AST_VOL_CLEAR: assert property (abort_op |-> ##[0:1] (!write_enable_latch
      && !suspend_flag && read_param_bits == 8'h00 && continuous_read_bits == 8'h00))
    else $error("volatile state kept over reset");
  AST_OUT_IDLE: assert property (cs_b [*6] |-> serial_out_en_b)
    else $error("output driven while deselected");
  AST_NO_RERESET: assert property (reset_busy && $past(reset_busy) |-> !abort_op)
    else $error("reset taken during recovery");
endmodule
bind sfl_cmd sfl_cmd_asserts #(.TRST_CYC(TRST_CYC)) sfl_cmd_asserts_inst (.ref_clk, .rst_b,
  .clk_en, .cs_b, .protect_scheme_select, .serial_out_en_b, .query_locked, .lock_scheme_active,
  .abort_op, .reset_busy, .write_enable_latch, .suspend_flag, .read_param_bits,
  .continuous_read_bits);

// ### sfl_host_model.sv
// Host controller model shifting mode-0 frames into the lock block
`timescale 1ns/10ps
module sfl_host_model (
  input wire logic ref_clk,
  input wire logic serial_out,
  input wire logic serial_out_en_b,
  output logic cs_b,
  output logic sclk,
  output logic serial_in
);
  initial begin
    cs_b = 1'b1;
    sclk = 1'b0;
    serial_in = 1'b0;
  end
  // Four cycles a phase keeps well under the quarter-rate limit
  task automatic half();
    repeat (4) @(negedge ref_clk);
  endtask
  // Undriven output reads as unknown so it can never match
  task automatic frame(input logic [7:0] op, input logic [31:0] a, input int na,
      input int nr, output logic [7:0] rb);
    logic [39:0] sh;
    sh = (na == 24) ? {op, a[23:0], 8'h00} : {op, a};
    rb = 8'h00;
    @(negedge ref_clk);
    cs_b = 1'b0;
    for (int i = 0; i < 8 + na + nr; i++) begin
      serial_in = (i < 8 + na) ? sh[39 - i] : ~serial_in;
      half();
      if (i >= 8 + na) rb = {rb[6:0], serial_out_en_b ? 1'bx : serial_out};
      sclk = 1'b1;
      half();
      sclk = 1'b0;
    end
    serial_in = ~serial_in;
    cs_b = 1'b1;
    half();
    half();
  endtask
endmodule

// ### sfl_cmd_tb.sv
// Self-checking bench for the lock and soft-reset command block
`timescale 1ns/10ps
module sfl_cmd_tb;
  localparam int TRST = 200;
  logic ref_clk, rst_b, clk_en, cs_b, sclk, serial_in, addr4_mode, busy;
  logic protect_scheme_select, protect_complement, top_bottom_select;
  logic [3:0] block_protect_level;
  logic write_enable_latch_set, suspend_set, read_param_load, cont_read_load;
  logic [7:0] read_param_in, cont_read_in, rb, read_param_bits, continuous_read_bits;
  logic [31:0] query_addr, a;
  logic serial_out, serial_out_en_b, query_locked, lock_scheme_active, abort_op, reset_busy;
  logic write_enable_latch, suspend_flag;
  logic lk [512];
  int n_errors, cmp_count, cyc, n_abort, nb;
  sfl_cmd #(.TRST_CYC(TRST)) sfl_cmd_inst (.ref_clk, .rst_b, .clk_en, .cs_b, .sclk,
    .serial_in, .addr4_mode, .protect_scheme_select, .protect_complement, .top_bottom_select,
    .block_protect_level, .write_enable_latch_set, .suspend_set, .busy, .read_param_in,
    .read_param_load, .cont_read_in, .cont_read_load, .query_addr, .serial_out,
    .serial_out_en_b, .query_locked, .lock_scheme_active, .abort_op, .reset_busy,
    .write_enable_latch, .suspend_flag, .read_param_bits, .continuous_read_bits);
  sfl_host_model sfl_host_model_inst (.ref_clk, .serial_out, .serial_out_en_b, .cs_b, .sclk,
    .serial_in);
  // ****************************************
  // Checking helpers
  // ****************************************
  function automatic int unit(input logic [31:0] ad);
    return int'(ad[24:16]);
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic op(input logic [7:0] o, input logic [31:0] ad, input int n);
    sfl_host_model_inst.frame(o, ad, n, 0, rb);
  endtask
  task automatic rdchk(input logic [31:0] ad);
    sfl_host_model_inst.frame(8'h3D, ad, nb, 8, rb);
    check({24'h0, rb}, {31'h0, lk[unit(ad)]});
  endtask
  task automatic close_out();
    if (n_errors == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // Ceiling is about twice the expected run
  always @(posedge ref_clk) begin
    cyc++;
    if (abort_op === 1'b1) n_abort++;
    if (cyc == 60000) begin
      n_errors++;
      close_out();
    end
  end
  initial begin
    {rst_b, write_enable_latch_set, suspend_set, read_param_load, cont_read_load} = 5'h00;
    {clk_en, protect_scheme_select, addr4_mode, busy} = 4'hC;
    void'($urandom(31276));
    {protect_complement, top_bottom_select, block_protect_level} = 6'($urandom());
    read_param_in = 8'($urandom());
    cont_read_in = 8'($urandom());
    query_addr = 32'h0;
    repeat (2) @(negedge ref_clk);
    rst_b = 1'b1;
    foreach (lk[i]) lk[i] = 1'b1;
    for (int k = 0; k < 10; k++) begin
      addr4_mode = (k >= 5);
      nb = addr4_mode ? 32 : 24;
      busy = 1'($urandom_range(1));
      a = $urandom() & (addr4_mode ? 32'h01FF_FFFF : 32'h00FF_FFFF);
      if (k == 0) a = 32'h0;
      if (k == 9) a = 32'h01FF_FFFF;
      rdchk(a);
      op(8'h39, a, nb - 8);
      rdchk(a);
      op(8'h39, a, nb);
      lk[unit(a)] = 1'b0;
      rdchk(a ^ 32'h0000_FFFF);
      rdchk(a ^ 32'h0001_0000);
      query_addr = a;
      protect_scheme_select = 1'($urandom_range(1));
      repeat (4) @(negedge ref_clk);
      check({31'h0, query_locked}, {31'h0, lk[unit(a)] & protect_scheme_select});
      op(8'h36, a, nb);
      lk[unit(a)] = 1'b1;
      rdchk(a);
    end
    op(8'h98, 32'h0, 0);
    foreach (lk[i]) lk[i] = 1'b0;
    rdchk(a ^ 32'h00F0_0000);
    op(8'h7E, 32'h0, 0);
    foreach (lk[i]) lk[i] = 1'b1;
    rdchk(a);
    op(8'h98, 32'h0, 0);
    foreach (lk[i]) lk[i] = 1'b0;
    {write_enable_latch_set, suspend_set, read_param_load, cont_read_load} = 4'hF;
    @(negedge ref_clk);
    {write_enable_latch_set, suspend_set, read_param_load, cont_read_load} = 4'h0;
    repeat (2) @(negedge ref_clk);
    check({14'h0, write_enable_latch, suspend_flag, read_param_bits, continuous_read_bits},
      {14'h0, 1'b1, ~busy, read_param_in, cont_read_in});
    // A read between the pair must disarm it
    op(8'h66, 32'h0, 0);
    rdchk(a);
    op(8'h99, 32'h0, 0);
    check({31'h0, reset_busy}, 32'h0);
    busy = 1'b0;
    op(8'h66, 32'h0, 0);
    op(8'h99, 32'h0, 0);
    check({31'h0, reset_busy}, 32'h1);
    check(n_abort, 32'h1);
    op(8'h98, 32'h0, 0);
    for (int i = 0; i < 400 && reset_busy === 1'b1; i++) @(negedge ref_clk);
    check({31'h0, reset_busy}, 32'h0);
    check({14'h0, write_enable_latch, suspend_flag, read_param_bits, continuous_read_bits},
      32'h0);
    foreach (lk[i]) lk[i] = 1'b1;
    rdchk(a);
    close_out();
  end
endmodule
